/* File: dv/phase_shed_config_test.sv */
// Purpose: self-checking bench of the phase shedding config bank
// Assumes: engine outputs follow inputs one edge later
// Notes: channel a exercised, channel b left with shedding off
module phase_shed_config_test;
  timeunit 1ns;
  timeprecision 1ps;
  logic mclk_i = 1'b0;
  logic nrst_i = 1'b0;
  logic valid, write, word, ack, nack, a_dcm, b_dcm;
  logic [7:0] cmd;
  logic [7:0] a_avg = 8'h00;
  logic [7:0] a_peak = 8'h00;
  logic [15:0] wdata, rdata;
  logic [1:0] a_cnt, b_cnt;
  logic [8:0] a_mv, b_mv;
  int num_errors = 0;
  int n_compared = 0;
  int cycles = 0;
  localparam int IEFF = 14;

  always #5 mclk_i = ~mclk_i;

  phase_shed_host host (.mclk_i(mclk_i), .xfer_valid_o(valid), .xfer_write_o(write), .xfer_word_o(word),
    .xfer_cmd_o(cmd), .xfer_wdata_o(wdata), .xfer_rdata_i(rdata), .xfer_ack_i(ack), .xfer_nack_i(nack));

  phase_shed_config DUT (.mclk_i(mclk_i), .nrst_i(nrst_i), .xfer_valid_i(valid), .xfer_write_i(write),
    .xfer_word_i(word), .xfer_cmd_i(cmd), .xfer_wdata_i(wdata), .xfer_rdata_o(rdata), .xfer_ack_o(ack),
    .xfer_nack_o(nack), .a_avg_current_i(a_avg), .a_peak_current_i(a_peak), .a_phase_count_o(a_cnt),
    .a_dcm_enable_o(a_dcm), .a_ramp_mv_o(a_mv), .b_avg_current_i(8'hc8), .b_peak_current_i(8'h00),
    .b_phase_count_o(b_cnt), .b_dcm_enable_o(b_dcm), .b_ramp_mv_o(b_mv));

  //////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
    n_compared++;
    if (seen !== exp) begin
      num_errors++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic end_of_test;
    $display("compared %0d mismatches %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  // one transaction, checks accept or refuse and read data
  task automatic acc(input logic wr, input logic wd, input logic [7:0] c, input logic [15:0] d,
                     input logic ok, input logic [15:0] exp);
    logic [15:0] r;
    logic a, n;
    host.xfer(wr, wd, c, d, cycles % 2, r, a, n);
    chk("ack", {15'h0000, a}, {15'h0000, ok});
    chk("nack", {15'h0000, n}, {15'h0000, ~ok});
    if (!wr && ok) chk("rdata", r, exp);
  endtask

  task automatic step(input int avg, input int peak, input int n, input logic [1:0] c, input logic dcm,
                      input logic [8:0] mv);
    @(posedge mclk_i);
    a_avg <= avg[7:0];
    a_peak <= peak[7:0];
    repeat (n) @(posedge mclk_i);
    #1;
    chk("count", {14'h0000, a_cnt}, {14'h0000, c});
    chk("dcm", {15'h0000, a_dcm}, {15'h0000, dcm});
    chk("ramp", {7'h00, a_mv}, {7'h00, mv});
  endtask

  //////////////////////////////////////////////////////////////////////////////
  task automatic t_reset;
    step(200, 0, 1, 2'd3, 1'b0, 9'h028);
    acc(1'b0, 1'b1, phase_shed_pkg::CMD_THRESH, 16'h0000, 1'b1, 16'h0000);
    acc(1'b0, 1'b1, phase_shed_pkg::CMD_RAMP_CFG, 16'h0000, 1'b1, 16'h0000);
    acc(1'b0, 1'b0, phase_shed_pkg::CMD_PAGE, 16'h0000, 1'b1, 16'h0000);
    $display("test reset done");
  endtask

  task automatic t_paging;
    acc(1'b1, 1'b0, phase_shed_pkg::CMD_PAGE, {8'h00, phase_shed_pkg::PAGE_B}, 1'b1, 16'h0000);
    acc(1'b1, 1'b1, phase_shed_pkg::CMD_THRESH, 16'h1234, 1'b1, 16'h0000);
    acc(1'b1, 1'b0, phase_shed_pkg::CMD_PAGE, {8'h00, phase_shed_pkg::PAGE_A}, 1'b1, 16'h0000);
    acc(1'b0, 1'b1, phase_shed_pkg::CMD_THRESH, 16'h0000, 1'b1, 16'h0000);
    acc(1'b1, 1'b0, phase_shed_pkg::CMD_PAGE, 16'h0002, 1'b0, 16'h0000);
    acc(1'b0, 1'b0, phase_shed_pkg::CMD_PAGE, 16'h0000, 1'b1, 16'h0000);
    acc(1'b1, 1'b0, phase_shed_pkg::CMD_THRESH, 16'hffff, 1'b0, 16'h0000);
    acc(1'b0, 1'b0, phase_shed_pkg::CMD_RAMP_CFG, 16'h0000, 1'b0, 16'h0000);
    acc(1'b1, 1'b1, phase_shed_pkg::CMD_PAGE, 16'h0001, 1'b0, 16'h0000);
    acc(1'b0, 1'b1, 8'h55, 16'h0000, 1'b0, 16'h0000);
    acc(1'b1, 1'b0, phase_shed_pkg::CMD_PAGE, {8'h00, phase_shed_pkg::PAGE_B}, 1'b1, 16'h0000);
    acc(1'b0, 1'b1, phase_shed_pkg::CMD_THRESH, 16'h0000, 1'b1, 16'h1234);
    acc(1'b1, 1'b0, phase_shed_pkg::CMD_PAGE, {8'h00, phase_shed_pkg::PAGE_A}, 1'b1, 16'h0000);
    $display("test paging done");
  endtask

  task automatic t_ramp;
    for (int code = 0; code < 8; code++) begin
      acc(1'b1, 1'b1, phase_shed_pkg::CMD_RAMP_CFG, 16'(code), 1'b1, 16'h0000);
      @(posedge mclk_i);
      #1;
      chk("ramp code", {7'h00, a_mv}, 16'((code + 1) * 40));
    end
    $display("test ramp done");
  endtask

  task automatic t_shed;
    acc(1'b1, 1'b1, phase_shed_pkg::CMD_THRESH, 16'he069, 1'b1, 16'h0000);
    acc(1'b1, 1'b1, phase_shed_pkg::CMD_RAMP_CFG, 16'h028d, 1'b1, 16'h0000);
    step(2 * IEFF + 3, 0, 2, 2'd3, 1'b0, 9'h0f0);
    step(2 * IEFF + 2, 0, 2, 2'd2, 1'b0, 9'h0f0);
    step(IEFF + 5, 0, 2, 2'd2, 1'b0, 9'h0f0);
    step(IEFF + 4, 0, 2, 2'd1, 1'b1, 9'h050);
    step(200, IEFF + 9, 2, 2'd1, 1'b1, 9'h050);
    step(200, IEFF + 10, 1, 2'd2, 1'b0, 9'h0f0);
    step(200, 2 * IEFF + 7, 2, 2'd2, 1'b0, 9'h0f0);
    step(200, 2 * IEFF + 8, 1, 2'd3, 1'b0, 9'h0f0);
    step(IEFF + 4, 0, 1, 2'd2, 1'b0, 9'h0f0);
    step(200, 2 * IEFF + 8, 1, 2'd2, 1'b0, 9'h0f0);
    acc(1'b1, 1'b1, phase_shed_pkg::CMD_THRESH, 16'he061, 1'b1, 16'h0000);
    step(IEFF + 4, 0, 3, 2'd2, 1'b0, 9'h0f0);
    acc(1'b1, 1'b1, phase_shed_pkg::CMD_THRESH, 16'h6069, 1'b1, 16'h0000);
    step(IEFF + 4, 0, 2, 2'd1, 1'b0, 9'h050);
    acc(1'b1, 1'b1, phase_shed_pkg::CMD_RAMP_CFG, 16'h020d, 1'b1, 16'h0000);
    step(IEFF + 4, 0, 3, 2'd3, 1'b0, 9'h0f0);
    $display("test shed done");
  endtask

  task automatic t_coarse;
    int ie;
    // raise the load first so enabling shedding cannot drop phases before the sweep starts
    step(200, 0, 1, 2'd3, 1'b0, 9'h0f0);
    acc(1'b1, 1'b1, phase_shed_pkg::CMD_RAMP_CFG, 16'h0080, 1'b1, 16'h0000);
    for (int c = 0; c < 4; c++) begin
      ie = 12 + 2 * c;
      acc(1'b1, 1'b1, phase_shed_pkg::CMD_THRESH, 16'h0008 | 16'(c), 1'b1, 16'h0000);
      step(2 * ie - 1, 0, 2, 2'd3, 1'b0, 9'h028);
      step(2 * ie - 2, 0, 1, 2'd2, 1'b0, 9'h028);
      step(200, 2 * ie + 6, 1, 2'd3, 1'b0, 9'h028);
    end
    chk("b count", {14'h0000, b_cnt}, 16'h0003);
    chk("b dcm", {15'h0000, b_dcm}, 16'h0000);
    chk("b ramp", {7'h00, b_mv}, 16'h0028);
    $display("test coarse done");
  endtask

  //////////////////////////////////////////////////////////////////////////////
  always @(posedge mclk_i) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      num_errors++;
      end_of_test();
    end
  end

  initial begin
    repeat (5) @(posedge mclk_i);
    nrst_i <= 1'b1;
    t_reset();
    t_paging();
    t_ramp();
    t_shed();
    t_coarse();
    end_of_test();
  end
endmodule

/* File: dv/phase_shed_host.sv */
// Purpose: host model issuing word and byte transactions to the config bank
// Assumes: answer is registered on the taking edge and read just after it
// Notes: released write data shows the inverse of the last value
module phase_shed_host (
  // clock
  input wire logic mclk_i,
  // request side
  output logic xfer_valid_o,
  output logic xfer_write_o,
  output logic xfer_word_o,
  output logic [7:0] xfer_cmd_o,
  output logic [15:0] xfer_wdata_o,
  // answer side
  input wire logic [15:0] xfer_rdata_i,
  input wire logic xfer_ack_i,
  input wire logic xfer_nack_i
);
  timeunit 1ns;
  timeprecision 1ps;

  initial begin
    xfer_valid_o = 1'b0;
    xfer_write_o = 1'b0;
    xfer_word_o = 1'b1;
    xfer_cmd_o = 8'h00;
    xfer_wdata_o = 16'h0000;
  end

  task automatic xfer(input logic wr, input logic wd, input logic [7:0] cmd, input logic [15:0] wdata,
                      input int gap, output logic [15:0] rdata, output logic ack, output logic nack);
    repeat (gap) @(posedge mclk_i);
    @(posedge mclk_i);
    xfer_valid_o <= 1'b1;
    xfer_write_o <= wr;
    xfer_word_o <= wd;
    xfer_cmd_o <= cmd;
    xfer_wdata_o <= wdata;
    @(posedge mclk_i);
    xfer_valid_o <= 1'b0;
    xfer_wdata_o <= ~wdata;
    #1;
    ack = xfer_ack_i;
    nack = xfer_nack_i;
    rdata = xfer_rdata_i;
  endtask
endmodule

/* File: src/phase_shed_channel.sv */
// Purpose: phase count engine and ramp decode for one channel
// Assumes: current samples are synchronous to mclk_i
// Notes: phase count moves one step per clock at most
module phase_shed_channel (
  // clock and reset
  input wire logic mclk_i,
  input wire logic nrst_i,
  // configuration words of this channel
  input wire logic [15:0] thresh_i,
  input wire logic [15:0] cfg_i,
  // current samples
  input wire logic [7:0] avg_current_i,
  input wire logic [7:0] peak_current_i,
  // results
  output logic [1:0] phase_count_o,
  output logic dcm_enable_o,
  output logic [8:0] ramp_mv_o
);

  typedef enum logic [1:0] {PH_ONE, PH_TWO, PH_THREE} phase_e;

  typedef struct packed {
    phase_e phase;
    logic [1:0] count;
    logic dcm;
    logic [8:0] ramp;
  } chan_s;

  localparam chan_s CHAN_RESET = '{PH_THREE, 2'h3, 1'b0, phase_shed_pkg::RAMP_STEP_MV};

  chan_s q;
  chan_s d;
  logic [7:0] ieff;
  logic [7:0] drop21;
  logic [7:0] add12;
  logic [7:0] add23;
  logic [7:0] drop32;
  logic shed_en;
  logic shed1_en;

  ////////////////////////////////////////////////////////////////////////////
  // thresholds and phase stepping
  always_comb begin
    d = q;
    ieff = phase_shed_pkg::IEFF_BASE_A + {5'h00, thresh_i[phase_shed_pkg::COARSE_LSB +: 2], 1'b0};
    drop21 = ieff + {5'h00, thresh_i[phase_shed_pkg::DROP21_LSB +: 2], 1'b0} - phase_shed_pkg::DROP_BELOW_A;
    add12 = ieff + phase_shed_pkg::ADD_BASE_A + {5'h00, thresh_i[phase_shed_pkg::ADD12_LSB +: 2], 1'b0};
    add23 = {ieff[6:0], 1'b0} + phase_shed_pkg::ADD_BASE_A
      + {5'h00, thresh_i[phase_shed_pkg::ADD23_LSB +: 2], 1'b0};
    drop32 = {ieff[6:0], 1'b0} + {5'h00, cfg_i[phase_shed_pkg::DROP32_LSB +: 2], 1'b0}
      - phase_shed_pkg::DROP_BELOW_A;
    shed_en = cfg_i[phase_shed_pkg::SHED_EN_BIT];
    shed1_en = thresh_i[phase_shed_pkg::SHED1_BIT];
    unique case (q.phase)
      PH_ONE: begin
        // leave one phase when not permitted
        if (!shed_en || !shed1_en || peak_current_i >= add12) begin
          d.phase = PH_TWO;
        end
      end
      PH_TWO: begin
        // disabled shedding climbs back to full
        if (!shed_en || peak_current_i >= add23) begin
          d.phase = PH_THREE;
        end else if (shed1_en && avg_current_i <= drop21) begin
          d.phase = PH_ONE;
        end
      end
      PH_THREE: begin
        if (shed_en && avg_current_i <= drop32) begin
          d.phase = PH_TWO;
        end
      end
    endcase
    unique case (d.phase)
      PH_ONE: d.count = 2'h1;
      PH_TWO: d.count = 2'h2;
      PH_THREE: d.count = 2'h3;
    endcase
    d.dcm = (d.phase == PH_ONE) && thresh_i[phase_shed_pkg::DCM_BIT];
    d.ramp = 9'(({6'h00, cfg_i[phase_shed_pkg::RAMP_LSB +: 3]} + 9'h001) * phase_shed_pkg::RAMP_STEP_MV);
    if (d.phase == PH_ONE && cfg_i[phase_shed_pkg::DYN_1PH_BIT]) begin
      d.ramp = phase_shed_pkg::RAMP_1PH_MV;
    end else if (d.phase == PH_TWO && cfg_i[phase_shed_pkg::DYN_2PH_BIT]) begin
      d.ramp = phase_shed_pkg::RAMP_2PH_MV;
    end
  end

  always_ff @(posedge mclk_i) begin
    if (!nrst_i) begin
      q <= CHAN_RESET;
    end else begin
      q <= d;
    end
  end

  assign phase_count_o = q.count;
  assign dcm_enable_o = q.dcm;
  assign ramp_mv_o = q.ramp;

  ////////////////////////////////////////////////////////////////////////////
  // checks
  step_one_a: assert property (@(posedge mclk_i) disable iff (!nrst_i)
    (q.count != $past(q.count)) |-> (q.count == $past(q.count) + 2'h1 || q.count + 2'h1 == $past(q.count)))
    else $error("phase count jumped by more than one");
  no_single_a: assert property (@(posedge mclk_i) disable iff (!nrst_i)
    !thresh_i[phase_shed_pkg::SHED1_BIT] |=> q.count != 2'h1)
    else $error("single phase reached while not permitted");
  disabled_full_a: assert property (@(posedge mclk_i) disable iff (!nrst_i)
    (!cfg_i[phase_shed_pkg::SHED_EN_BIT])[*2] |=> q.count == 2'h3)
    else $error("shedding disabled but not at three phases");
  dcm_gate_a: assert property (@(posedge mclk_i) disable iff (!nrst_i)
    q.dcm |-> q.count == 2'h1 && $past(thresh_i[phase_shed_pkg::DCM_BIT]))
    else $error("discontinuous mode outside enabled single phase");
  ramp_decode_a: assert property (@(posedge mclk_i) disable iff (!nrst_i)
    cfg_i[4:3] == 2'b00 |=> q.ramp == 9'(({6'h00, $past(cfg_i[2:0])} + 9'h001) * 9'h028))
    else $error("ramp amplitude decode wrong");
  add_second_a: assert property (@(posedge mclk_i) disable iff (!nrst_i)
    q.count == 2'h1 && peak_current_i >= 8'(8'h12 + {5'h00, thresh_i[1:0], 1'b0} + {5'h00, thresh_i[5:4], 1'b0})
    |=> q.count == 2'h2)
    else $error("second phase not added");
  add_third_a: assert property (@(posedge mclk_i) disable iff (!nrst_i)
    q.count == 2'h2 && peak_current_i >= 8'(8'h1e + {4'h0, thresh_i[1:0], 2'b00} + {5'h00, thresh_i[7:6], 1'b0})
    |=> q.count == 2'h3)
    else $error("third phase not added");
  drop_two_a: assert property (@(posedge mclk_i) disable iff (!nrst_i)
    q.count == 2'h2 && cfg_i[7] && thresh_i[3] && peak_current_i < add23
    && avg_current_i <= 8'(8'h0a + {5'h00, thresh_i[1:0], 1'b0} + {5'h00, thresh_i[14:13], 1'b0})
    |=> q.count == 2'h1)
    else $error("drop to one phase missed");
  drop_three_a: assert property (@(posedge mclk_i) disable iff (!nrst_i)
    q.count == 2'h3 && cfg_i[7]
    && avg_current_i <= 8'(8'h16 + {4'h0, thresh_i[1:0], 2'b00} + {5'h00, cfg_i[9:8], 1'b0})
    |=> q.count == 2'h2)
    else $error("drop to two phases missed");

endmodule

/* File: src/phase_shed_config.sv */
// Purpose: paged phase shedding configuration bank with two channel engines
// Assumes: a bus front end delivers decoded word and byte transactions
// Notes: ack and nack are one-cycle pulses one edge after the request

//////////////////////////////////////////////////////////////////////////////
// Notes on behaviour
// - ramp codes give 40 to 320 mV
// - word stored per channel, page selects
// - bit 15 allows discontinuous single phase
// - two-to-one drop at ieff plus offset
// - third phase added at twice ieff plus
// - second phase added at ieff plus offset
// - bit 3 clear forbids single phase
// - coarse field picks 12 to 18 A
// - ramp code sits in companion bits 2:0
// - companion bit 7 enables shedding
// - three-to-two drop at twice ieff plus offset
module phase_shed_config #(
  parameter logic [15:0] THRESH_INIT = phase_shed_pkg::THRESH_RESET,
  parameter logic [15:0] CFG_INIT = phase_shed_pkg::CFG_RESET
) (
  // clock and reset
  input wire logic mclk_i,
  input wire logic nrst_i,
  // decoded bus transactions
  input wire logic xfer_valid_i,
  input wire logic xfer_write_i,
  input wire logic xfer_word_i,
  input wire logic [7:0] xfer_cmd_i,
  input wire logic [15:0] xfer_wdata_i,
  output logic [15:0] xfer_rdata_o,
  output logic xfer_ack_o,
  output logic xfer_nack_o,
  // channel a current samples and results
  input wire logic [7:0] a_avg_current_i,
  input wire logic [7:0] a_peak_current_i,
  output logic [1:0] a_phase_count_o,
  output logic a_dcm_enable_o,
  output logic [8:0] a_ramp_mv_o,
  // channel b current samples and results
  input wire logic [7:0] b_avg_current_i,
  input wire logic [7:0] b_peak_current_i,
  output logic [1:0] b_phase_count_o,
  output logic b_dcm_enable_o,
  output logic [8:0] b_ramp_mv_o
);

  typedef struct packed {
    logic page;
    logic [1:0][15:0] thresh;
    logic [1:0][15:0] cfg;
    logic [15:0] rdata;
    logic ack;
    logic nack;
  } bank_s;

  localparam bank_s BANK_RESET = '{1'b0, {THRESH_INIT, THRESH_INIT}, {CFG_INIT, CFG_INIT},
    phase_shed_pkg::RDATA_RESET, 1'b0, 1'b0};

  bank_s q;
  bank_s d;

  ////////////////////////////////////////////////////////////////////////////
  // transaction decode
  always_comb begin
    d = q;
    d.ack = 1'b0;
    d.nack = 1'b0;
    if (xfer_valid_i) begin
      unique case (xfer_cmd_i)
        phase_shed_pkg::CMD_PAGE: begin
          if (xfer_word_i) begin
            d.nack = 1'b1;
          end else if (xfer_write_i) begin
            if (xfer_wdata_i[7:0] == phase_shed_pkg::PAGE_A || xfer_wdata_i[7:0] == phase_shed_pkg::PAGE_B) begin
              d.page = xfer_wdata_i[0];
              d.ack = 1'b1;
            end else begin
              d.nack = 1'b1;
            end
          end else begin
            d.rdata = {15'h0000, q.page};
            d.ack = 1'b1;
          end
        end
        phase_shed_pkg::CMD_THRESH, phase_shed_pkg::CMD_RAMP_CFG: begin
          if (!xfer_word_i) begin
            d.nack = 1'b1;
          end else begin
            d.ack = 1'b1;
            // access lands on the paged channel
            if (xfer_write_i && xfer_cmd_i == phase_shed_pkg::CMD_THRESH) begin
              d.thresh[q.page] = xfer_wdata_i;
            end else if (xfer_write_i) begin
              d.cfg[q.page] = xfer_wdata_i;
            end else if (xfer_cmd_i == phase_shed_pkg::CMD_THRESH) begin
              d.rdata = q.thresh[q.page];
            end else begin
              d.rdata = q.cfg[q.page];
            end
          end
        end
        default: begin
          d.nack = 1'b1;
        end
      endcase
    end
  end

  always_ff @(posedge mclk_i) begin
    if (!nrst_i) begin
      q <= BANK_RESET;
    end else begin
      q <= d;
    end
  end

  assign xfer_rdata_o = q.rdata;
  assign xfer_ack_o = q.ack;
  assign xfer_nack_o = q.nack;

  ////////////////////////////////////////////////////////////////////////////
  // channel engines
  // fixed field layout shared by both channels
  phase_shed_channel chan_a (
    .mclk_i(mclk_i),
    .nrst_i(nrst_i),
    .thresh_i(q.thresh[0]),
    .cfg_i(q.cfg[0]),
    .avg_current_i(a_avg_current_i),
    .peak_current_i(a_peak_current_i),
    .phase_count_o(a_phase_count_o),
    .dcm_enable_o(a_dcm_enable_o),
    .ramp_mv_o(a_ramp_mv_o)
  );

  // ramp code taken from companion bits 2:0
  phase_shed_channel chan_b (
    .mclk_i(mclk_i),
    .nrst_i(nrst_i),
    .thresh_i(q.thresh[1]),
    .cfg_i(q.cfg[1]),
    .avg_current_i(b_avg_current_i),
    .peak_current_i(b_peak_current_i),
    .phase_count_o(b_phase_count_o),
    .dcm_enable_o(b_dcm_enable_o),
    .ramp_mv_o(b_ramp_mv_o)
  );

  ////////////////////////////////////////////////////////////////////////////
  // checks
  paged_store_a: assert property (@(posedge mclk_i) disable iff (!nrst_i)
    xfer_valid_i && xfer_write_i && xfer_word_i && xfer_cmd_i == 8'hdf
    |=> q.thresh[$past(q.page)] == $past(xfer_wdata_i) && q.thresh[!$past(q.page)] == $past(q.thresh[!q.page]))
    else $error("threshold write hit wrong channel");
  byte_refused_a: assert property (@(posedge mclk_i) disable iff (!nrst_i)
    xfer_valid_i && !xfer_word_i && (xfer_cmd_i == 8'hdf || xfer_cmd_i == 8'hde)
    |=> q.nack && !q.ack && $stable(q.thresh) && $stable(q.cfg))
    else $error("byte access to word register not refused");
  paged_read_a: assert property (@(posedge mclk_i) disable iff (!nrst_i)
    xfer_valid_i && !xfer_write_i && xfer_word_i && xfer_cmd_i == 8'hde
    |=> q.ack && q.rdata == $past(q.cfg[q.page]))
    else $error("config read returned wrong channel");

endmodule

/* File: src/phase_shed_pkg.sv */
// Purpose: shared constants of the phase shedding configuration bank
// Assumes: currents in whole amperes, ramp amplitudes in millivolts
// Notes: CMD_THRESH and CMD_RAMP_CFG are word commands and CMD_PAGE a byte command on the management bus
package phase_shed_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // command codes and page values
  localparam logic [7:0] CMD_PAGE = 8'h00;
  localparam logic [7:0] CMD_RAMP_CFG = 8'hde;
  localparam logic [7:0] CMD_THRESH = 8'hdf;
  localparam logic [7:0] PAGE_A = 8'h00;
  localparam logic [7:0] PAGE_B = 8'h01;

  ////////////////////////////////////////////////////////////////////////////
  // phase_shed_thresholds field layout
  localparam int DCM_BIT = 15;
  localparam int DROP21_LSB = 13;
  localparam int ADD23_LSB = 6;
  localparam int ADD12_LSB = 4;
  localparam int SHED1_BIT = 3;
  localparam int COARSE_LSB = 0;

  ////////////////////////////////////////////////////////////////////////////
  // ramp_and_shed_config field layout
  localparam int DROP32_LSB = 8;
  localparam int SHED_EN_BIT = 7;
  localparam int DYN_2PH_BIT = 4;
  localparam int DYN_1PH_BIT = 3;
  localparam int RAMP_LSB = 0;

  ////////////////////////////////////////////////////////////////////////////
  // reset values (stand in for the nonvolatile defaults)
  localparam logic [15:0] THRESH_RESET = 16'h0000;
  localparam logic [15:0] CFG_RESET = 16'h0000;
  localparam logic [15:0] RDATA_RESET = 16'h0000;

  ////////////////////////////////////////////////////////////////////////////
  // threshold arithmetic, amperes
  localparam logic [7:0] IEFF_BASE_A = 8'h0c;
  localparam logic [7:0] ADD_BASE_A = 8'h06;
  localparam logic [7:0] DROP_BELOW_A = 8'h02;

  ////////////////////////////////////////////////////////////////////////////
  // ramp amplitudes, millivolts
  localparam logic [8:0] RAMP_STEP_MV = 9'h028;
  localparam logic [8:0] RAMP_1PH_MV = 9'h050;
  localparam logic [8:0] RAMP_2PH_MV = 9'h078;

endpackage
